//--- include/timer_defs.svh
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH

// register byte offsets
`define OFS_CTRL0      8'h00
`define OFS_CTRL1      8'h04
`define OFS_CNT_LOW    8'h08
`define OFS_CNT_HIGH   8'h0C
`define OFS_CMPA_LOW   8'h10
`define OFS_CMPA_HIGH  8'h14
`define OFS_PIN_SHARE  8'h18

// reset values
`define CTRL0_RST      8'h00
`define CTRL1_RST      8'h00
`define CMPA_RST       10'h000
`define CNT_RST        10'h000
`define BUF_RST        8'h00

// field positions
`define SHARE_BIT      0
`define HIGH_BITS      1:0
`define LOW_BITS       7:0

// counter and comparator geometry
`define CNT_W          10
`define CNT_MAX        10'h3FF
`define PERIOD_LSB     7

// clock select codes
`define CKS_SYS_DIV4   3'h0
`define CKS_SYS        3'h1
`define CKS_H_DIV16    3'h2
`define CKS_H_DIV64    3'h3
`define CKS_TBC        3'h4
`define CKS_EXT_RISE   3'h6
`define CKS_EXT_FALL   3'h7

// prescaler terminal masks
`define PRE_W          10
`define PRE_DIV4       10'h003
`define PRE_DIV16      10'h00F
`define PRE_DIV64      10'h03F
`define PRE_TBC        10'h3FF

// capture edge select codes
`define CAP_RISE       2'h0
`define CAP_FALL       2'h1
`define CAP_BOTH       2'h2

// output action codes
`define OUT_LOW        2'h1
`define OUT_HIGH       2'h2
`define OUT_TOGGLE     2'h3
`define PWM_INACTIVE   2'h0
`define PWM_ACTIVE     2'h1
`define PWM_WAVE       2'h2
`define PWM_SINGLE     2'h3

`endif

//--- include/timer_pkg.sv
package timer_pkg;

    typedef enum logic [1:0] {
        MODE_COMPARE = 2'h0,
        MODE_CAPTURE = 2'h1,
        MODE_PWM     = 2'h2,
        MODE_TIMER   = 2'h3
    } operating_mode_t;

    typedef struct packed {
        logic       pause;
        logic [2:0] counter_clock_select;
        logic       on;
        logic [2:0] period_compare_value;
    } timer_control_0_t;

    typedef struct packed {
        operating_mode_t operating_mode_field;
        logic            pin_function_select_hi;
        logic            pin_function_select_lo;
        logic            out_ctrl;
        logic            polarity;
        logic            duplex;
        logic            clear_select;
    } timer_control_1_t;

    typedef struct packed {
        logic rise;
        logic fall;
    } pin_edges_t;

    typedef enum logic [2:0] {
        PULSE_IDLE   = 3'b001,
        PULSE_ACTIVE = 3'b010,
        PULSE_DONE   = 3'b100
    } pulse_state_t;

endpackage : timer_pkg

//--- hdl/count_clock_source.sv
`timescale 1ns/1ps
`include "timer_defs.svh"

module count_clock_source (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic [2:0]          clk_sel,
    input  wire logic                ext_count_clock_pin,
    input  wire logic                capture_input_pin,
    output logic                     count_tick,
    output timer_pkg::pin_edges_t    cap_edges
);

    // index 0: external count clock, index 1: capture input
    logic [1:0]        s1_q;
    logic [1:0]        s2_q;
    logic [1:0]        s3_q;
    logic [1:0]        lvl_q;
    logic [1:0]        lvl_d;
    logic [1:0]        stable;
    logic [1:0]        rise;
    logic [1:0]        fall;
    logic [`PRE_W-1:0] pre_q;
    logic              tick_d;
    logic              tick_q;
    timer_pkg::pin_edges_t edges_q;

    function automatic logic pre_at(input logic [`PRE_W-1:0] cnt,
                                    input logic [`PRE_W-1:0] mask);
        pre_at = (cnt & mask) == mask;
    endfunction : pre_at

    // an edge only counts once two late stages agree, filtering glitches
    assign stable = ~(s2_q ^ s3_q);
    assign lvl_d  = (stable & s3_q) | (~stable & lvl_q);
    assign rise   = stable & s3_q & ~lvl_q;
    assign fall   = stable & ~s3_q & lvl_q;

    always_comb begin
        case (clk_sel)
            `CKS_SYS_DIV4: tick_d = pre_at(pre_q, `PRE_DIV4);
            `CKS_SYS:      tick_d = 1'b1;
            `CKS_H_DIV16:  tick_d = pre_at(pre_q, `PRE_DIV16);
            `CKS_H_DIV64:  tick_d = pre_at(pre_q, `PRE_DIV64);
            `CKS_TBC:      tick_d = pre_at(pre_q, `PRE_TBC);
            `CKS_EXT_RISE: tick_d = rise[0];
            `CKS_EXT_FALL: tick_d = fall[0];
            default:       tick_d = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q    <= 2'h0;
            s2_q    <= 2'h0;
            s3_q    <= 2'h0;
            lvl_q   <= 2'h0;
            pre_q   <= '0;
            tick_q  <= 1'b0;
            edges_q <= '0;
        end else begin
            s1_q    <= {capture_input_pin, ext_count_clock_pin};
            s2_q    <= s1_q;
            s3_q    <= s2_q;
            lvl_q   <= lvl_d;
            pre_q   <= pre_q + 1'b1;
            tick_q  <= tick_d;
            edges_q <= '{rise: rise[1], fall: fall[1]};
        end
    end

    assign count_tick = tick_q;
    assign cap_edges  = edges_q;

endmodule : count_clock_source

//--- hdl/standard_timer.sv
//
// Function
// - one timer with ten-bit counter
// - match raises interrupt, may clear, drive pin
// - three-bit field selects counter clock
// - external pin clocks counter, chosen edge
// - external pin edges count events
// - separate interrupts for comparators A, P
// - capture on rise, fall or both
// - compare match sets, clears, toggles output
// - PWM uses same output pin
// - share bit routes output to pin
// - low bytes pass through 8-bit buffer
// - low write buffers, high write commits
// - high read latches low into buffer
// - four operating modes supported
// - PWM and single pulse, duty or period
// - count up, P top bits, A full
// - clock select codes as encoded
// - mode field codes as encoded
//
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "timer_defs.svh"

module standard_timer (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ext_count_clock_pin,
    input  wire logic        capture_input_pin,
    input  wire logic        other_function_out,
    output logic             timer_output_pin,
    output logic             compare_a_irq,
    output logic             compare_p_irq
);

    timer_pkg::timer_control_0_t ctrl0_q;
    timer_pkg::timer_control_1_t ctrl1_q;
    timer_pkg::pulse_state_t     pulse_q;
    timer_pkg::pulse_state_t     pulse_d;
    timer_pkg::pin_edges_t       cap_edges;
    timer_pkg::operating_mode_t  mode;

    logic [`CNT_W-1:0] cnt_q;
    logic [`CNT_W-1:0] cnt_d;
    logic [`CNT_W-1:0] cmpa_q;
    logic [`CNT_W-1:0] cmpa_d;
    logic [7:0]        buf_q;
    logic [7:0]        buf_d;
    logic              share_q;
    logic              on_last_q;
    logic              out_q;
    logic              out_d;
    logic              pin_q;
    logic              irq_a_q;
    logic              irq_p_q;
    logic [31:0]       prdata_q;
    logic [31:0]       rd_mux;
    logic              pready_q;
    logic              pslverr_q;
    logic              count_tick;

    function automatic logic addr_is(input logic [7:0] a,
                                     input logic [7:0] ofs);
        addr_is = a == ofs;
    endfunction : addr_is

    // count sits on a 128-tick boundary named by the period field
    function automatic logic on_boundary(input logic [`CNT_W-1:0] c,
                                         input logic [2:0]        p);
        on_boundary = (c[9:`PERIOD_LSB] == p)
                    && (c[`PERIOD_LSB-1:0] == 7'h00);
    endfunction : on_boundary

    // bus decode
    wire setup_ph  = psel & ~penable;
    wire access_ok = psel & penable & pready_q;
    wire wr        = access_ok & pwrite;
    wire rd_setup  = setup_ph & ~pwrite;

    wire hit_c0    = addr_is(paddr, `OFS_CTRL0);
    wire hit_c1    = addr_is(paddr, `OFS_CTRL1);
    wire hit_dl    = addr_is(paddr, `OFS_CNT_LOW);
    wire hit_dh    = addr_is(paddr, `OFS_CNT_HIGH);
    wire hit_al    = addr_is(paddr, `OFS_CMPA_LOW);
    wire hit_ah    = addr_is(paddr, `OFS_CMPA_HIGH);
    wire hit_sh    = addr_is(paddr, `OFS_PIN_SHARE);
    wire mapped    = hit_c0 | hit_c1 | hit_dl | hit_dh | hit_al
                   | hit_ah | hit_sh;

    wire wr_c0     = wr & hit_c0;
    wire wr_c1     = wr & hit_c1;
    wire wr_al     = wr & hit_al;
    wire wr_ah     = wr & hit_ah;
    wire wr_sh     = wr & hit_sh;

    count_clock_source u_clock_source (
        .pclk                (pclk),
        .presetn             (presetn),
        .clk_sel             (ctrl0_q.counter_clock_select),
        .ext_count_clock_pin (ext_count_clock_pin),
        .capture_input_pin   (capture_input_pin),
        .count_tick          (count_tick),
        .cap_edges           (cap_edges)
    );

    assign mode = ctrl1_q.operating_mode_field;

    wire [1:0] io_sel = {ctrl1_q.pin_function_select_hi,
                         ctrl1_q.pin_function_select_lo};
    wire       oc     = ctrl1_q.out_ctrl;
    wire [2:0] rp     = ctrl0_q.period_compare_value;

    // counter restarts from zero on the off-to-on transition and on a clearing match
    wire on_rise = ctrl0_q.on & ~on_last_q;
    wire run     = ctrl0_q.on & ~ctrl0_q.pause & count_tick;

    // P fires on the tick that carries the count onto rp*128, so the
    // period is rp*128 ticks; rp=0 wraps from the top, giving 1024
    wire [`CNT_W-1:0] cnt_nx = cnt_q + 10'h001;
    wire p_hit   = on_boundary(cnt_nx, rp);
    wire a_hit   = cnt_q == cmpa_q;

    wire is_cap  = mode == timer_pkg::MODE_CAPTURE;
    wire is_pwm  = mode == timer_pkg::MODE_PWM;
    wire match_p = run & p_hit;
    wire match_a = run & a_hit & ~is_cap;

    wire cap_sel = (io_sel == `CAP_RISE) ? cap_edges.rise
                 : (io_sel == `CAP_FALL) ? cap_edges.fall
                 : (io_sel == `CAP_BOTH) ? (cap_edges.rise
                                            | cap_edges.fall)
                 : 1'b0;
    wire cap_ev  = is_cap & ctrl0_q.on & cap_sel;

    // in PWM the duplex bit decides which comparator sets the period
    wire clr_on_a = is_pwm ? ctrl1_q.duplex
                  : (ctrl1_q.clear_select & ~is_cap);
    wire cnt_clr  = clr_on_a ? match_a : match_p;

    always_comb begin
        if (on_rise) begin
            cnt_d = `CNT_RST;
        end else if (run) begin
            cnt_d = cnt_clr ? `CNT_RST : cnt_nx;
        end else begin
            cnt_d = cnt_q;
        end
    end

    // capture has priority over a concurrent software commit
    always_comb begin
        if (cap_ev) begin
            cmpa_d = cnt_q;
        end else if (wr_ah) begin
            cmpa_d = {pwdata[`HIGH_BITS], buf_q};
        end else begin
            cmpa_d = cmpa_q;
        end
    end

    // bus access to a low byte only ever moves through the shared buffer; capture loads all of A directly
    always_comb begin
        if (wr_al) begin
            buf_d = pwdata[`LOW_BITS];
        end else if (rd_setup & hit_dh) begin
            buf_d = cnt_q[`LOW_BITS];
        end else if (rd_setup & hit_ah) begin
            buf_d = cmpa_q[`LOW_BITS];
        end else begin
            buf_d = buf_q;
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_c0) begin
            rd_mux[7:0] = ctrl0_q;
        end else if (hit_c1) begin
            rd_mux[7:0] = ctrl1_q;
        end else if (hit_dl | hit_al) begin
            rd_mux[7:0] = buf_q;
        end else if (hit_dh) begin
            rd_mux[`HIGH_BITS] = cnt_q[9:8];
        end else if (hit_ah) begin
            rd_mux[`HIGH_BITS] = cmpa_q[9:8];
        end else if (hit_sh) begin
            rd_mux[`SHARE_BIT] = share_q;
        end
    end

    // duty window: period by P and duty by A, or swapped with duplex
    wire [`CNT_W-1:0] p_edge  = {rp, 7'h00};
    wire              in_duty = ctrl1_q.duplex ? (cnt_q < p_edge)
                                               : (cnt_q < cmpa_q);

    // a finished pulse re-arms only while single pulse is still chosen
    wire pulse_arm = on_rise & is_pwm & (io_sel == `PWM_SINGLE);

    always_comb begin
        pulse_d = pulse_q;
        case (pulse_q)
            timer_pkg::PULSE_IDLE: begin
                if (pulse_arm) begin
                    pulse_d = timer_pkg::PULSE_ACTIVE;
                end
            end
            timer_pkg::PULSE_ACTIVE: begin
                if (match_a | ~ctrl0_q.on) begin
                    pulse_d = timer_pkg::PULSE_DONE;
                end
            end
            timer_pkg::PULSE_DONE: begin
                if (pulse_arm) begin
                    pulse_d = timer_pkg::PULSE_ACTIVE;
                end
            end
            default: pulse_d = timer_pkg::PULSE_IDLE;
        endcase
    end

    // output level before polarity; active level follows out_ctrl
    always_comb begin
        out_d = out_q;
        case (mode)
            timer_pkg::MODE_COMPARE: begin
                if (on_rise) begin
                    out_d = oc;
                end else if (match_a) begin
                    case (io_sel)
                        `OUT_LOW:    out_d = 1'b0;
                        `OUT_HIGH:   out_d = 1'b1;
                        `OUT_TOGGLE: out_d = ~out_q;
                        default:     out_d = out_q;
                    endcase
                end
            end
            timer_pkg::MODE_PWM: begin
                case (io_sel)
                    `PWM_INACTIVE: out_d = ~oc;
                    `PWM_ACTIVE:   out_d = oc;
                    `PWM_WAVE:     out_d = ctrl0_q.on & in_duty
                                           ? oc : ~oc;
                    `PWM_SINGLE:   out_d = (pulse_d ==
                                            timer_pkg::PULSE_ACTIVE)
                                           ? oc : ~oc;
                    default:       out_d = out_q;
                endcase
            end
            // capture and timer modes leave the level untouched
            default: out_d = out_q;
        endcase
    end

    wire pin_d = share_q ? (out_q ^ ctrl1_q.polarity)
                         : other_function_out;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl0_q <= timer_pkg::timer_control_0_t'(`CTRL0_RST);
        end else if (wr_c0) begin
            ctrl0_q <= timer_pkg::timer_control_0_t'(pwdata[7:0]);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl1_q <= timer_pkg::timer_control_1_t'(`CTRL1_RST);
        end else if (wr_c1) begin
            ctrl1_q <= timer_pkg::timer_control_1_t'(pwdata[7:0]);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            share_q <= 1'b0;
        end else if (wr_sh) begin
            share_q <= pwdata[`SHARE_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q     <= `CNT_RST;
            cmpa_q    <= `CMPA_RST;
            buf_q     <= `BUF_RST;
            on_last_q <= 1'b0;
            pulse_q   <= timer_pkg::PULSE_IDLE;
        end else begin
            cnt_q     <= cnt_d;
            cmpa_q    <= cmpa_d;
            buf_q     <= buf_d;
            on_last_q <= ctrl0_q.on;
            pulse_q   <= pulse_d;
        end
    end

    // capture shares the A interrupt line, as it shares the A register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_q   <= 1'b0;
            pin_q   <= 1'b0;
            irq_a_q <= 1'b0;
            irq_p_q <= 1'b0;
        end else begin
            out_q   <= out_d;
            pin_q   <= pin_d;
            irq_a_q <= match_a | cap_ev;
            irq_p_q <= match_p;
        end
    end

    // one wait-free access phase; read effects land in setup, once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= setup_ph;
            pslverr_q <= setup_ph & ~mapped;
            if (rd_setup) begin
                prdata_q <= rd_mux;
            end
        end
    end

    assign prdata           = prdata_q;
    assign pready           = pready_q;
    assign pslverr          = pslverr_q;
    assign timer_output_pin = pin_q;
    assign compare_a_irq    = irq_a_q;
    assign compare_p_irq    = irq_p_q;

endmodule : standard_timer

//--- tb/standard_timer_asserts.sv
`timescale 1ns/1ps
module standard_timer_asserts (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        ext_count_clock_pin,
    input wire logic        capture_input_pin,
    input wire logic        other_function_out,
    input wire logic        timer_output_pin,
    input wire logic        compare_a_irq,
    input wire logic        compare_p_irq
);
    logic share_q;
    logic on_q;
    wire  wr_ok  = psel && penable && pready && pwrite && !pslverr;
    wire  mapped = paddr[1:0] == 2'h0 && paddr <= 8'h18;
    wire  hi_rd  = pready && !pwrite && (paddr == 8'h0C || paddr == 8'h14);
    // shadow of share and on bits, followed from bus writes only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            share_q <= 1'b0;
            on_q    <= 1'b0;
        end else if (wr_ok) begin
            if (paddr == 8'h18) share_q <= pwdata[0];
            if (paddr == 8'h00) on_q <= pwdata[3];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_ready_cause: assert property (pready |-> psel && penable
        && $past(psel && !penable)) else $error("pready out of place");
    chk_ready_due: assert property (psel && !penable |=> pready)
        else $error("pready late");
    chk_err_map: assert property (pready |-> pslverr == !mapped)
        else $error("pslverr wrong");
    chk_err_rdzero: assert property (pready && pslverr && !pwrite
        |-> prdata == 32'h0) else $error("refused read not zero");
    chk_high_width: assert property (hi_rd |-> prdata[31:2] == 30'h0)
        else $error("high byte too wide");
    chk_pin_other: assert property ($past(presetn) && !$past(share_q)
        |-> timer_output_pin == $past(other_function_out))
        else $error("pin not given to other function");
    chk_p_off: assert property (!on_q && !$past(on_q)
        && !$past(on_q, 2) |-> !compare_p_irq) else $error("irq when off");
    chk_p_single: assert property (compare_p_irq |=> !compare_p_irq)
        else $error("period irq repeated");
    cov_a: cover property (compare_a_irq);
    cov_p: cover property (compare_p_irq);
    cov_err: cover property (pready && pslverr);
endmodule : standard_timer_asserts

bind standard_timer standard_timer_asserts i_standard_timer_asserts (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .ext_count_clock_pin, .capture_input_pin,
    .other_function_out, .timer_output_pin, .compare_a_irq, .compare_p_irq
);

//--- tb/pin_driver.sv
`timescale 1ns/1ps
module pin_driver (
    input  wire logic pclk,
    input  wire logic ext_run,
    input  wire logic cap_go,
    output logic      ext_count_clock_pin,
    output logic      capture_input_pin
);
    int ext_cnt = 0;
    int cap_cnt = 0;
    initial begin
        ext_count_clock_pin = 1'b0;
        capture_input_pin   = 1'b0;
    end
    // levels held 10 cycles so every edge clears the synchroniser
    always @(posedge pclk) begin
        if (ext_run) begin
            ext_cnt <= (ext_cnt == 9) ? 0 : ext_cnt + 1;
            if (ext_cnt == 9) ext_count_clock_pin <= !ext_count_clock_pin;
        end
        if (cap_go && cap_cnt == 0) cap_cnt <= 20;
        else if (cap_cnt != 0) cap_cnt <= cap_cnt - 1;
        capture_input_pin <= cap_cnt > 10;
    end
endmodule : pin_driver

//--- tb/tb_top.sv
`timescale 1ns/1ps
`define CHK(what, exp, got) begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
        failures++; \
        $display("CHECK FAILED %s exp %0h got %0h", what, exp, got); \
    end \
end
module tb_top;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, timer_output_pin;
    logic        compare_a_irq, compare_p_irq;
    logic        ext_count_clock_pin, capture_input_pin;
    logic        other_function_out = 1'b0;
    logic        ext_run = 1'b0;
    logic        cap_go = 1'b0;
    logic [31:0] rng = 32'h2FCEA101;
    logic [31:0] orng = 32'h2FCEA101;
    int          failures = 0;
    int          cmp_count = 0;
    logic [7:0]  ofs[7] = '{8'h00, 8'h04, 8'h0C, 8'h08, 8'h14, 8'h10,
                            8'h18};
    logic [2:0]  sels[7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h7};
    int          divs[7] = '{4, 1, 16, 64, 1024, 20, 20};
    always #12.5 pclk = ~pclk;
    standard_timer i_standard_timer (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .ext_count_clock_pin, .capture_input_pin, .other_function_out,
        .timer_output_pin, .compare_a_irq, .compare_p_irq);
    pin_driver i_pin_driver (.pclk, .ext_run, .cap_go,
        .ext_count_clock_pin, .capture_input_pin);
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    function automatic int period(input int div, input int n);
        return (n + 1) * div;
    endfunction : period
    always @(posedge pclk) begin
        orng <= xs(orng);
        other_function_out <= orng[0];
    end
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, {24'h0, d}, r, e);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, r, e);
    endtask : rd
    task automatic wait_irq(input logic p, output int n);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while ((p ? compare_p_irq : compare_a_irq) !== 1'b1);
    endtask : wait_irq
    task automatic test_done();
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : test_done
    initial begin
        repeat (60000) @(posedge pclk);
        failures++;
        test_done();
    end
    initial begin
        logic [31:0] r;
        logic        e;
        logic [9:0]  v;
        logic        p0;
        int          n;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (ofs[i]) begin
            rd(ofs[i], r);
            `CHK("reset value", 32'h0, r)
        end
        apb(1'b0, 8'h1C, 32'h0, r, e);
        `CHK("unmapped refused", 1'b1, e)
        wr(8'h0C, 8'h03);
        rd(8'h0C, r);
        `CHK("counter read only", 32'h0, r)
        repeat (4) begin
            rng = xs(rng);
            v = rng[9:0];
            wr(8'h10, v[7:0]);
            wr(8'h14, {6'h0, v[9:8]});
            wr(8'h10, ~v[7:0]);
            rd(8'h14, r);
            `CHK("compare a high", {30'h0, v[9:8]}, r)
            rd(8'h10, r);
            `CHK("compare a low", {24'h0, v[7:0]}, r)
        end
        // match at 3 clears on A, toggles the shared pin
        wr(8'h10, 8'h03);
        wr(8'h14, 8'h00);
        wr(8'h18, 8'h01);
        wr(8'h04, {timer_pkg::MODE_COMPARE, 2'h3, 4'h1});
        foreach (sels[i]) begin
            ext_run <= sels[i] >= 3'h6;
            wr(8'h00, {1'b0, sels[i], 4'h0});
            wr(8'h00, {1'b0, sels[i], 4'h8});
            wait_irq(1'b0, n);
            p0 = timer_output_pin;
            wait_irq(1'b0, n);
            `CHK("a match interval", period(divs[i], 3), n)
            `CHK("pin toggled", ~p0, timer_output_pin)
        end
        wr(8'h04, {timer_pkg::MODE_COMPARE, 2'h0, 4'h0});
        for (int k = 1; k >= 0; k--) begin
            wr(8'h00, {5'h02, k[2:0]});
            wr(8'h00, {5'h03, k[2:0]});
            wait_irq(1'b1, n);
            wait_irq(1'b1, n);
            `CHK("p match interval", (k == 0) ? 1024 : 128, n)
        end
        // no clock source, so only capture edges raise the irq
        for (int k = 0; k < 3; k++) begin
            wr(8'h00, 8'h50);
            wr(8'h04, {timer_pkg::MODE_CAPTURE, k[1:0], 4'h0});
            wr(8'h00, 8'h58);
            cap_go <= 1'b1;
            @(posedge pclk);
            cap_go <= 1'b0;
            n = 0;
            repeat (40) begin
                @(posedge pclk);
                if (compare_a_irq === 1'b1) n++;
            end
            `CHK("capture count", (k == 2) ? 2 : 1, n)
        end
        rd(8'h14, r);
        rd(8'h10, r);
        `CHK("captured value", 32'h0, r)
        wr(8'h18, 8'h00);
        repeat (30) @(posedge pclk);
        test_done();
    end
endmodule : tb_top
